// [src/bert_checker.sv]
// Summary of operation
// - Positive edge setting samples data on rising feedback clock edges.
// - Negative edge setting samples data on falling feedback clock edges.
// - External restart on: measurement reset comes from the restart pin.
// - Restart rising: produce partial result and halt measurement.
// - Restart falling: start next subinterval, resynchronise pattern from scratch.
// - External restart resets measurement whatever masking does.
// - External restart off: measurement reset generated internally.
// - Software enables mask input and selects its active polarity.
// - With masking on, unmarked bits are neither compared nor counted.
// - Masking off: mask input ignored, every bit evaluated.
// - Low or high polarity evaluates bits only at that mask level.
// - Pattern generator holds state while bits are masked out.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bert_checker (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [bert_pkg::WB_AW-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [bert_pkg::WB_DW-1:0] wbDatI,
  output logic [bert_pkg::WB_DW-1:0] wbDatO,
  output logic wbAck,
  // Link pins from the device under test
  input wire logic linkClk,
  input wire logic linkData,
  input wire logic bitMaskInput,
  input wire logic linkRestart,
  // Status levels
  output logic measDone
);
  import bert_pkg::*;

  // ************************************************
  // Register file
  // ************************************************
  logic [CTRL_W-1:0] ctrl_reg;
  logic [WB_DW-1:0] totalBits_reg;
  logic [WB_DW-1:0] totalErrs_reg;
  logic overflow_reg;
  logic busHit;
  logic busWrite;
  logic [WB_DW-1:0] readMux;

  function automatic logic [WB_DW-1:0] merge(input logic [WB_DW-1:0] old, input logic [WB_DW-1:0] nw,
                                             input logic [3:0] sel);
    logic [WB_DW-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  assign busHit = wbCyc && wbStb && !wbAck;
  assign busWrite = busHit && wbWe;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wbAck <= 1'b0;
    end else if (ce) begin
      wbAck <= busHit;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET;
      totalBits_reg <= TOTAL_BITS_RESET;
      totalErrs_reg <= TOTAL_ERRS_RESET;
    end else if (ce && busWrite) begin
      case (wbAdr)
        ADDR_CTRL: ctrl_reg <= CTRL_W'(merge(WB_DW'(ctrl_reg), wbDatI, wbSel));
        ADDR_TOTAL_BITS: totalBits_reg <= merge(totalBits_reg, wbDatI, wbSel);
        ADDR_TOTAL_ERRS: totalErrs_reg <= merge(totalErrs_reg, wbDatI, wbSel);
        default: ;
      endcase
    end
  end

  // ************************************************
  // Pin synchronisers and edge finding
  // ************************************************
  logic [3:0] pinMeta_reg;
  logic [3:0] pinSync_reg;
  logic clkPrev_reg;
  logic sampleStrobe;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
      clkPrev_reg <= 1'b0;
    end else if (ce) begin
      pinMeta_reg <= {linkRestart, bitMaskInput, linkData, linkClk};
      pinSync_reg <= pinMeta_reg;
      clkPrev_reg <= pinSync_reg[0];
    end
  end

  assign sampleStrobe = ctrl_reg[CTRL_NEG_EDGE] ? (clkPrev_reg && !pinSync_reg[0])
                                                : (!clkPrev_reg && pinSync_reg[0]);

  // ************************************************
  // Sample buffer
  // ************************************************
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [SAMPLE_W-1:0] fifoOut;
  logic [SAMPLE_W-1:0] fifoIn;

  assign fifoIn = {pinSync_reg[3], pinSync_reg[2], pinSync_reg[1]};
  // Software hold lets the buffer fill; samples then lost are flagged
  assign fifoOutReady = !ctrl_reg[CTRL_HOLD];

  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) sample_fifo_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .inValid(sampleStrobe),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );

  // Set wins over the software clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      overflow_reg <= 1'b0;
    end else if (ce) begin
      if (sampleStrobe && !fifoInReady) begin
        overflow_reg <= 1'b1;
      end else if (busWrite && wbAdr == ADDR_STATUS && wbSel[0] && wbDatI[STAT_OVERFLOW]) begin
        overflow_reg <= 1'b0;
      end
    end
  end

  // ************************************************
  // Bit evaluation
  // ************************************************
  meas_state_e state_reg;
  meas_state_e state_next;
  logic [LFSR_W-1:0] lfsr_reg;
  logic [3:0] syncCnt_reg;
  logic restartPrev_reg;
  logic runPrev_reg;
  logic [WB_DW-1:0] curBits_reg;
  logic [WB_DW-1:0] curErrs_reg;
  logic [WB_DW-1:0] accBits_reg;
  logic [WB_DW-1:0] accErrs_reg;
  logic [WB_DW-1:0] partBits_reg;
  logic [WB_DW-1:0] partErrs_reg;
  logic take;
  logic rxBit;
  logic bitEnabled;
  logic restartRise;
  logic restartFall;
  logic runRise;
  logic evalBit;
  logic mismatch;
  logic reachTotal;
  logic startSync;
  logic latchPart;

  function automatic logic prbsBit(input logic [LFSR_W-1:0] s);
    prbsBit = s[LFSR_TAP_A] ^ s[LFSR_TAP_B];
  endfunction : prbsBit

  assign take = fifoOutValid && fifoOutReady;
  assign rxBit = fifoOut[SMP_DATA];
  assign bitEnabled = !ctrl_reg[CTRL_MASK_EN] || (fifoOut[SMP_MASK] == ctrl_reg[CTRL_MASK_HIGH]);
  assign restartRise = take && ctrl_reg[CTRL_EXT_RESTART] && fifoOut[SMP_RESTART] && !restartPrev_reg;
  assign restartFall = take && ctrl_reg[CTRL_EXT_RESTART] && !fifoOut[SMP_RESTART] && restartPrev_reg;
  assign runRise = ctrl_reg[CTRL_RUN] && !runPrev_reg;
  assign evalBit = take && bitEnabled && (state_reg == ST_MEAS);
  assign mismatch = rxBit != prbsBit(lfsr_reg);
  assign reachTotal = (accBits_reg >= totalBits_reg) || (accErrs_reg >= totalErrs_reg);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      restartPrev_reg <= 1'b0;
      runPrev_reg <= 1'b0;
    end else if (ce) begin
      runPrev_reg <= ctrl_reg[CTRL_RUN];
      if (take) begin
        restartPrev_reg <= fifoOut[SMP_RESTART];
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (runRise) begin
          state_next = ST_SYNC;
        end
      end
      ST_SYNC, ST_MEAS: begin
        if (restartRise) begin
          state_next = ST_HALT;
        end else if (state_reg == ST_SYNC && take && bitEnabled && syncCnt_reg == SYNC_LAST) begin
          state_next = ST_MEAS;
        end else if (state_reg == ST_MEAS && reachTotal) begin
          state_next = ST_DONE;
        end
      end
      ST_HALT: begin
        if (reachTotal) begin
          state_next = ST_DONE;
        end else if (restartFall || !ctrl_reg[CTRL_EXT_RESTART]) begin
          state_next = ST_SYNC;
        end
      end
      ST_DONE: ;
      default: state_next = ST_IDLE;
    endcase
    if (!ctrl_reg[CTRL_RUN]) begin
      state_next = ST_IDLE;
    end else if (runRise) begin
      state_next = ST_SYNC;
    end
  end

  assign startSync = (state_next == ST_SYNC) && (state_reg != ST_SYNC);
  assign latchPart = ((state_next == ST_HALT) || (state_next == ST_DONE)) &&
                     ((state_reg == ST_SYNC) || (state_reg == ST_MEAS));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Reference pattern; seeded from received bits while syncing
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lfsr_reg <= '0;
      syncCnt_reg <= '0;
    end else if (ce) begin
      if (startSync) begin
        syncCnt_reg <= '0;
      end else if (state_reg == ST_SYNC && take && bitEnabled) begin
        lfsr_reg <= {lfsr_reg[LFSR_W-2:0], rxBit};
        syncCnt_reg <= 4'(syncCnt_reg + 1'b1);
      end else if (evalBit) begin
        lfsr_reg <= {lfsr_reg[LFSR_W-2:0], prbsBit(lfsr_reg)};
      end
    end
  end

  // Run ends once accumulated bits or errors reach their totals
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      curBits_reg <= '0;
      curErrs_reg <= '0;
      accBits_reg <= '0;
      accErrs_reg <= '0;
    end else if (ce) begin
      if (runRise) begin
        accBits_reg <= '0;
        accErrs_reg <= '0;
        curBits_reg <= '0;
        curErrs_reg <= '0;
      end else if (startSync) begin
        curBits_reg <= '0;
        curErrs_reg <= '0;
      end else if (evalBit && !restartRise) begin
        curBits_reg <= curBits_reg + 1'b1;
        accBits_reg <= accBits_reg + 1'b1;
        if (mismatch) begin
          curErrs_reg <= curErrs_reg + 1'b1;
          accErrs_reg <= accErrs_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      partBits_reg <= '0;
      partErrs_reg <= '0;
    end else if (ce && latchPart) begin
      partBits_reg <= curBits_reg;
      partErrs_reg <= curErrs_reg;
    end
  end

  // ************************************************
  // Read path and status output
  // ************************************************
  always_comb begin
    readMux = '0;
    case (wbAdr)
      ADDR_CTRL: readMux = WB_DW'(ctrl_reg);
      ADDR_STATUS: begin
        readMux[STAT_SYNC] = (state_reg == ST_SYNC);
        readMux[STAT_MEAS] = (state_reg == ST_MEAS);
        readMux[STAT_HALT] = (state_reg == ST_HALT);
        readMux[STAT_DONE] = (state_reg == ST_DONE);
        readMux[STAT_OVERFLOW] = overflow_reg;
      end
      ADDR_TOTAL_BITS: readMux = totalBits_reg;
      ADDR_TOTAL_ERRS: readMux = totalErrs_reg;
      ADDR_ACC_BITS: readMux = accBits_reg;
      ADDR_ACC_ERRS: readMux = accErrs_reg;
      ADDR_PART_BITS: readMux = partBits_reg;
      ADDR_PART_ERRS: readMux = partErrs_reg;
      default: readMux = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wbDatO <= '0;
      measDone <= 1'b0;
    end else if (ce) begin
      measDone <= (state_next == ST_DONE);
      if (busHit && !wbWe) begin
        wbDatO <= readMux;
      end
    end
  end

endmodule : bert_checker
`default_nettype wire

// [src/bert_pkg.sv]
package bert_pkg;

  // ************************************************
  // Bus and register map
  // ************************************************
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam logic [WB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [WB_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [WB_AW-1:0] ADDR_TOTAL_BITS = 8'h08;
  localparam logic [WB_AW-1:0] ADDR_TOTAL_ERRS = 8'h0c;
  localparam logic [WB_AW-1:0] ADDR_ACC_BITS = 8'h10;
  localparam logic [WB_AW-1:0] ADDR_ACC_ERRS = 8'h14;
  localparam logic [WB_AW-1:0] ADDR_PART_BITS = 8'h18;
  localparam logic [WB_AW-1:0] ADDR_PART_ERRS = 8'h1c;

  // ************************************************
  // Control and status fields
  // ************************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_NEG_EDGE = 1;
  localparam int CTRL_EXT_RESTART = 2;
  localparam int CTRL_MASK_EN = 3;
  localparam int CTRL_MASK_HIGH = 4;
  localparam int CTRL_HOLD = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam int STAT_SYNC = 0;
  localparam int STAT_MEAS = 1;
  localparam int STAT_HALT = 2;
  localparam int STAT_DONE = 3;
  localparam int STAT_OVERFLOW = 4;
  localparam logic [WB_DW-1:0] TOTAL_BITS_RESET = 32'hffffffff;
  localparam logic [WB_DW-1:0] TOTAL_ERRS_RESET = 32'hffffffff;

  // ************************************************
  // Sample stream and reference pattern
  // ************************************************
  localparam int FIFO_DEPTH = 8;
  localparam int SAMPLE_W = 3;
  localparam int SMP_DATA = 0;
  localparam int SMP_MASK = 1;
  localparam int SMP_RESTART = 2;
  localparam int LFSR_W = 15;
  localparam int LFSR_TAP_A = 14;
  localparam int LFSR_TAP_B = 13;
  localparam logic [3:0] SYNC_LAST = 4'he;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SYNC,
    ST_MEAS,
    ST_HALT,
    ST_DONE
  } meas_state_e;

endpackage : bert_pkg

// [src/sample_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  logic doWrite;
  logic doLoad;

  assign inReady = (count_reg != FULL_COUNT);
  assign doWrite = inValid && inReady;
  // Output register refills as soon as it empties or is taken
  assign doLoad = (count_reg != '0) && (!outValid || outReady);

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST_PTR) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  always_ff @(posedge mclk) begin
    if (ce && doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      if (doWrite) begin
        wrPtr_reg <= bump(wrPtr_reg);
      end
      if (doLoad) begin
        rdPtr_reg <= bump(rdPtr_reg);
      end
      count_reg <= (PW+1)'(count_reg + doWrite - doLoad);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (ce) begin
      if (doLoad) begin
        outValid <= 1'b1;
        outData <= mem[rdPtr_reg];
      end else if (outReady) begin
        outValid <= 1'b0;
      end
    end
  end

endmodule : sample_fifo
`default_nettype wire

// [bench/bert_checker_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Bus and status checks
// *****
module bert_checker_properties (
  // Clock and control
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [bert_pkg::WB_AW-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [bert_pkg::WB_DW-1:0] wbDatI,
  input wire logic [bert_pkg::WB_DW-1:0] wbDatO,
  input wire logic wbAck,
  // Link and status
  input wire logic linkClk,
  input wire logic linkData,
  input wire logic bitMaskInput,
  input wire logic linkRestart,
  input wire logic measDone
);
  import bert_pkg::*;
  logic linkPrev;
  logic [5:0] quietCount;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Cycles since a link clock change or a bus write
  always_ff @(posedge mclk) begin
    linkPrev <= linkClk;
    if (!reset_n || linkClk != linkPrev || (wbCyc && wbStb && wbWe)) begin
      quietCount <= 6'h00;
    end else if (quietCount != 6'h3f) begin
      quietCount <= quietCount + 6'h01;
    end
  end
  sequence s_take;
    ce && wbCyc && wbStb && !wbAck;
  endsequence
  sequence s_read;
    s_take ##0 !wbWe;
  endsequence
  property p_ack_after_take;
    s_take |=> wbAck;
  endproperty
  property p_ack_single;
    wbAck && ce |=> !wbAck;
  endproperty
  property p_no_spurious;
    ce && !(wbCyc && wbStb) |=> !wbAck;
  endproperty
  property p_dato_holds;
    !(wbCyc && wbStb && !wbWe && !wbAck) |=> $stable(wbDatO);
  endproperty
  property p_done_bit;
    s_read ##0 (wbAdr == ADDR_STATUS) |=> wbDatO[STAT_DONE] == $past(measDone);
  endproperty
  property p_unmapped;
    s_read ##0 (wbAdr == 8'h20) |=> wbDatO == 32'h0;
  endproperty
  // Done holds until software writes
  property p_done_stays;
    (!(wbCyc && wbStb && wbWe))[*4] ##0 measDone |=> measDone;
  endproperty
  property p_done_cause;
    $rose(measDone) |-> quietCount < 6'h18;
  endproperty
  a_ack_after_take: assert property (p_ack_after_take) else $error("no ack after request");
  a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
  a_no_spurious: assert property (p_no_spurious) else $error("ack without request");
  a_dato_holds: assert property (p_dato_holds) else $error("read data changed");
  a_done_bit: assert property (p_done_bit) else $error("status done differs");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_done_stays: assert property (p_done_stays) else $error("done dropped");
  a_done_cause: assert property (p_done_cause) else $error("done without activity");
endmodule : bert_checker_properties
bind bert_checker bert_checker_properties bert_checker_properties_inst (.mclk(mclk), .reset_n(reset_n),
  .ce(ce), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
  .wbDatO(wbDatO), .wbAck(wbAck), .linkClk(linkClk), .linkData(linkData), .bitMaskInput(bitMaskInput),
  .linkRestart(linkRestart), .measDone(measDone));
`default_nettype wire

// [bench/bert_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Device under test on the link
// *****
module bert_link_model (
  // Link pins
  output logic linkClk,
  output logic linkData,
  output logic bitMaskInput,
  output logic linkRestart
);
  logic negMode;
  logic busy;
  logic [14:0] prbs;
  initial begin
    linkClk = 1'b0;
    linkData = 1'b0;
    bitMaskInput = 1'b0;
    linkRestart = 1'b0;
    negMode = 1'b0;
    busy = 1'b0;
    prbs = 15'h1d3b;
  end
  // Idle data and mask lines never keep a stale value
  always begin
    #37;
    if (!busy) begin
      linkData = ~linkData;
      bitMaskInput = ~bitMaskInput;
    end
  end
  task automatic send_bit(input logic d, input logic m, input logic r);
    linkClk = negMode;
    linkData = d;
    bitMaskInput = m;
    linkRestart = r;
    #80;
    linkClk = !negMode;
    #40;
    linkClk = 1'b0;
    #40;
  endtask : send_bit
  task automatic send_frame(input int nEn, input int nErr, input logic mEn, input logic mHigh, input logic rnd);
    int i;
    logic d;
    busy = 1'b1;
    i = 0;
    while (i < nEn) begin
      if (mEn && $urandom_range(3) == 0) begin
        send_bit(1'($urandom), !mHigh, rnd & 1'($urandom));
      end else begin
        d = prbs[14] ^ prbs[13];
        prbs = {prbs[13:0], d};
        // Errors only after the sync span
        if (i >= 15 && i < 15 + 3 * nErr && (i - 15) % 3 == 0) d = !d;
        send_bit(d, mEn ? mHigh : 1'($urandom), rnd & 1'($urandom));
        i++;
      end
    end
    busy = 1'b0;
  endtask : send_frame
  task automatic restart_pulse(input logic mHigh);
    busy = 1'b1;
    send_bit(1'b0, !mHigh, 1'b1);
    repeat (3) send_bit(1'($urandom), mHigh, 1'b1);
    send_bit(1'b1, !mHigh, 1'b0);
    prbs = 15'h4a31;
    busy = 1'b0;
  endtask : restart_pulse
endmodule : bert_link_model
`default_nettype wire

// [bench/bert_checker_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Self-checking bench
// *****
module bert_checker_tb;
  import bert_pkg::*;
  logic mclk, reset_n, ce, wbCyc, wbStb, wbWe, wbAck, measDone;
  logic linkClk, linkData, bitMaskInput, linkRestart;
  logic [WB_AW-1:0] wbAdr;
  logic [3:0] wbSel;
  logic [WB_DW-1:0] wbDatI, wbDatO, x;
  int failCount, comparisons, nb, ne, n1, n2;
  bert_checker bert_checker_inst (.mclk(mclk), .reset_n(reset_n), .ce(ce), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .linkClk(linkClk), .linkData(linkData), .bitMaskInput(bitMaskInput), .linkRestart(linkRestart),
    .measDone(measDone));
  bert_link_model bert_link_model_inst (.linkClk(linkClk), .linkData(linkData),
    .bitMaskInput(bitMaskInput), .linkRestart(linkRestart));
  always #5 mclk = ~mclk;
  task automatic completeRun();
    if (failCount == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : completeRun
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word
  // Classic cycle, held until ack is sampled
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [31:0] rd);
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    wbSel <= s;
    // No limit here: the watchdog ends a hung access
    do begin
      @(posedge mclk);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb_cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    wb_cycle(1'b1, a, d, 4'hf, t);
  endtask : wr
  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    wb_cycle(1'b0, a, 32'h0, 4'hf, t);
    check_word(t, exp);
  endtask : check_reg
  function automatic logic [31:0] ctrl(input logic neg, input logic ext, input logic mEn, input logic mHigh,
                                       input logic hold);
    logic [31:0] c;
    c = 32'h1;
    c[CTRL_NEG_EDGE] = neg;
    c[CTRL_EXT_RESTART] = ext;
    c[CTRL_MASK_EN] = mEn;
    c[CTRL_MASK_HIGH] = mHigh;
    c[CTRL_HOLD] = hold;
    return c;
  endfunction : ctrl
  // Bits left after the self-seeding sync span
  function automatic logic [31:0] exp_bits(input int n);
    return 32'(n - LFSR_W);
  endfunction : exp_bits
  // Far beyond the expected run of some 60 us
  initial begin
    #400000;
    failCount++;
    completeRun();
  end
  initial begin
    void'($urandom(32'h0ef5e458));
    mclk = 1'b0;
    reset_n = 1'b0;
    ce = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatI = 32'h0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    check_reg(ADDR_CTRL, 32'h0);
    check_reg(ADDR_TOTAL_BITS, TOTAL_BITS_RESET);
    wr(ADDR_ACC_BITS, 32'h5a5a5a5a);
    check_reg(ADDR_ACC_BITS, 32'h0);
    wr(8'h20, 32'h1);
    check_reg(8'h20, 32'h0);
    wb_cycle(1'b1, ADDR_TOTAL_ERRS, 32'h12345678, 4'h1, x);
    check_reg(ADDR_TOTAL_ERRS, 32'hffffff78);
    // Every edge and mask mode, random restart ignored
    for (int m = 0; m < 6; m++) begin
      nb = 24 + $urandom_range(8);
      ne = $urandom_range(3);
      bert_link_model_inst.negMode = 1'(m % 2);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CTRL, ctrl(1'(m % 2), 1'b0, m > 1, m > 3, 1'b0));
      bert_link_model_inst.send_frame(nb, ne, m > 1, m > 3, 1'b1);
      repeat (12) @(posedge mclk);
      check_reg(ADDR_ACC_BITS, exp_bits(nb));
      check_reg(ADDR_ACC_ERRS, 32'(ne));
      if (m == 0) begin
        // Frozen clock enable lets a whole frame pass unseen
        ce <= 1'b0;
        bert_link_model_inst.send_frame(20, 0, 1'b0, 1'b0, 1'b0);
        @(posedge mclk);
        ce <= 1'b1;
        check_reg(ADDR_ACC_BITS, exp_bits(nb));
      end
    end
    // Two subintervals summed up to the total
    n1 = 24 + $urandom_range(6);
    n2 = 24 + $urandom_range(6);
    bert_link_model_inst.negMode = 1'b0;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_TOTAL_BITS, exp_bits(n1) + exp_bits(n2));
    wr(ADDR_TOTAL_ERRS, 32'h0000ffff);
    wr(ADDR_CTRL, ctrl(1'b0, 1'b1, 1'b1, 1'b1, 1'b0));
    bert_link_model_inst.send_frame(n1, 1, 1'b1, 1'b1, 1'b0);
    bert_link_model_inst.restart_pulse(1'b1);
    repeat (12) @(posedge mclk);
    check_reg(ADDR_PART_BITS, exp_bits(n1));
    check_reg(ADDR_PART_ERRS, 32'h1);
    check_word({31'h0, measDone}, 32'h0);
    bert_link_model_inst.send_frame(n2, 2, 1'b1, 1'b1, 1'b0);
    repeat (12) @(posedge mclk);
    check_reg(ADDR_ACC_BITS, exp_bits(n1) + exp_bits(n2));
    check_reg(ADDR_ACC_ERRS, 32'h3);
    check_word({31'h0, measDone}, 32'h1);
    check_reg(ADDR_STATUS, 32'h8);
    // Stalled drain fills the buffer until it drops
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
    bert_link_model_inst.send_frame(12, 0, 1'b0, 1'b0, 1'b0);
    wb_cycle(1'b0, ADDR_STATUS, 32'h0, 4'hf, x);
    check_word({31'h0, x[STAT_OVERFLOW]}, 32'h1);
    wr(ADDR_STATUS, 32'h10);
    wb_cycle(1'b0, ADDR_STATUS, 32'h0, 4'hf, x);
    check_word({31'h0, x[STAT_OVERFLOW]}, 32'h0);
    // Mid-run reset, then the error total ends the run
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    check_reg(ADDR_STATUS, 32'h0);
    check_reg(ADDR_TOTAL_BITS, TOTAL_BITS_RESET);
    wr(ADDR_TOTAL_ERRS, 32'h2);
    wr(ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    bert_link_model_inst.send_frame(24, 3, 1'b0, 1'b0, 1'b0);
    repeat (12) @(posedge mclk);
    check_reg(ADDR_ACC_ERRS, 32'h2);
    // Second error is the fourth counted bit
    check_reg(ADDR_ACC_BITS, 32'h4);
    check_word({31'h0, measDone}, 32'h1);
    completeRun();
  end
endmodule : bert_checker_tb
`default_nettype wire
